// ---- logic/uafc_pkg.sv ----
package uafc_pkg;
  // ****************************************************
  // register indices on the host register port
  // ****************************************************
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IER = 4'h1;
  localparam logic [3:0] IDX_FCR_ISR = 4'h2;
  localparam logic [3:0] IDX_LCR = 4'h3;
  localparam logic [3:0] IDX_MCR = 4'h4;
  localparam logic [3:0] IDX_LSR = 4'h5;
  localparam logic [3:0] IDX_TCR = 4'h6;
  localparam logic [3:0] IDX_TRIG = 4'h7;
  localparam logic [3:0] IDX_EFR = 4'h8;
  localparam logic [3:0] IDX_DLD = 4'h9;
  // ****************************************************
  // reset values, sizes, codes
  // ****************************************************
  localparam logic [7:0] RST_LCR = 8'h03;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL = 7'h40;
  localparam logic [6:0] LEVEL_SCALE = 7'h04;
  localparam logic [1:0] OS_8X = 2'h1;
  localparam logic [1:0] OS_4X = 2'h2;
  localparam logic [4:0] BIT_TICKS_16X = 5'h10;
  localparam logic [5:0] TO_EXTRA_BITS = 6'h0c;
  localparam logic [1:0] TO_CHAR_SHIFT = 2'h2;
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_THR = 8'h02;
  localparam logic [7:0] ISR_RXD = 8'h04;
  localparam logic [7:0] ISR_TOUT = 8'h0c;
  localparam logic [7:0] ISR_FLOW = 8'h20;
  localparam int EFR_ENH = 4;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } uafc_req_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uafc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uafc_rx_st_t;
endpackage

// ---- logic/uafc_core.sv ----
`timescale 1ns/1ps
module uafc_core (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic SAMPLE_TICK_I,
  input wire uafc_pkg::uafc_req_t REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic RXD_I,
  output logic TXD_O,
  input wire logic CTS_N_I,
  output logic RTS_N_O,
  output logic IRQ_O
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] flow_threshold;
    logic [7:0] trig;
    logic [7:0] enhanced_feature;
    logic [7:0] fractional_divisor;
    logic fifo_en;
    logic [uafc_pkg::FIFO_DEPTH-1:0][7:0] txf;
    logic [5:0] tx_wp;
    logic [5:0] tx_rp;
    logic [6:0] tx_n;
    logic [uafc_pkg::FIFO_DEPTH-1:0][10:0] rxf;
    logic [5:0] rx_wp;
    logic [5:0] rx_rp;
    logic [6:0] rx_n;
    uafc_pkg::uafc_tx_st_t tx_st;
    logic [4:0] tx_tc;
    logic [2:0] tx_bi;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txd;
    uafc_pkg::uafc_rx_st_t rx_st;
    logic [4:0] rx_tc;
    logic [2:0] rx_bi;
    logic [7:0] rx_sh;
    logic rx_pbit;
    logic rx_prev;
    logic overrun;
    logic [9:0] to_cnt;
    logic to_flag;
    logic thr_cond;
    logic thr_arm;
    logic flow_flag;
    logic rts_n;
    logic cts_prev;
    logic irq;
    logic [7:0] rdata;
  } uafc_state_t;

  uafc_state_t s_q;
  uafc_state_t s_d;

  // ****************************************************
  // derived settings, from registered state except cts_hold, which also takes CTS_N_I directly
  // ****************************************************
  logic [4:0] len;
  logic [4:0] half;
  logic [3:0] wl;
  logic [7:0] wmask;
  logic [6:0] cap;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;
  logic [6:0] tx_trig;
  logic [6:0] rx_trig;
  logic [5:0] to_bits;
  logic [9:0] to_lim;
  logic rx_int;
  logic cts_hold;
  logic auto_rts;
  logic tx_empty;
  logic [7:0] lsr_v;
  logic [7:0] isr_v;

  // 11 falls back to 16x so a bad setting cannot stall the shifters
  always_comb begin
    case (s_q.fractional_divisor[5:4])
      uafc_pkg::OS_8X: len = uafc_pkg::BIT_TICKS_16X >> 1;
      uafc_pkg::OS_4X: len = uafc_pkg::BIT_TICKS_16X >> 2;
      default: len = uafc_pkg::BIT_TICKS_16X;
    endcase
  end

  // word length, levels, timeout span and status images
  always_comb begin
    half = len >> 1;
    wl = 4'h5 + {2'h0, s_q.line_control[1:0]};
    wmask = 8'hff >> (4'h8 - wl);
    cap = s_q.fifo_en ? uafc_pkg::FIFO_FULL : 7'h01;
    halt_lvl = {3'h0, s_q.flow_threshold[3:0]} * uafc_pkg::LEVEL_SCALE;
    resume_lvl = {3'h0, s_q.flow_threshold[7:4]} * uafc_pkg::LEVEL_SCALE;
    tx_trig = {3'h0, s_q.trig[3:0]} * uafc_pkg::LEVEL_SCALE;
    rx_trig = {3'h0, s_q.trig[7:4]} * uafc_pkg::LEVEL_SCALE;
    to_bits = ({2'h0, wl} << uafc_pkg::TO_CHAR_SHIFT) + uafc_pkg::TO_EXTRA_BITS;
    to_lim = {4'h0, to_bits} * {5'h0, len};
    rx_int = s_q.fifo_en ? (s_q.rx_n != 7'h00 && s_q.rx_n >= rx_trig)
                         : (s_q.rx_n != 7'h00);
    cts_hold = s_q.enhanced_feature[uafc_pkg::EFR_ACTS] & CTS_N_I;
    auto_rts = s_q.enhanced_feature[uafc_pkg::EFR_ARTS] & s_q.modem_control[1];
    tx_empty = (s_q.tx_n == 7'h00) && (s_q.tx_st == uafc_pkg::TX_IDLE);
    lsr_v = {1'b0, tx_empty, s_q.tx_n == 7'h00,
             s_q.rx_n != 7'h00 ? s_q.rxf[s_q.rx_rp][10:8] : 3'h0,
             s_q.overrun, s_q.rx_n != 7'h00};
    if (s_q.interrupt_enable[0] && s_q.to_flag) begin
      isr_v = uafc_pkg::ISR_TOUT;
    end else if (s_q.interrupt_enable[0] && rx_int) begin
      isr_v = uafc_pkg::ISR_RXD;
    end else if (s_q.interrupt_enable[1] && s_q.thr_arm) begin
      isr_v = uafc_pkg::ISR_THR;
    end else if (s_q.flow_flag) begin
      isr_v = uafc_pkg::ISR_FLOW;
    end else begin
      isr_v = uafc_pkg::ISR_NONE;
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [10:0] rx_word;
    logic tick;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_word = 11'h000;
    tick = SAMPLE_TICK_I;
    s_d = s_q;
    s_d.irq = (isr_v != uafc_pkg::ISR_NONE);
    // host writes; clears come first so a same-cycle set wins below
    if (REG_REQ_I.wr) begin
      case (REG_REQ_I.addr)
        uafc_pkg::IDX_DATA: begin
          s_d.thr_arm = 1'b0;
          if (s_q.tx_n < cap) begin
            s_d.txf[s_q.tx_wp] = REG_REQ_I.wdata;
            s_d.tx_wp = s_q.tx_wp + 6'h01;
            tx_push = 1'b1;
          end
        end
        uafc_pkg::IDX_IER: begin
          // upper enables are locked until the enhanced bit opens them
          s_d.interrupt_enable[3:0] = REG_REQ_I.wdata[3:0];
          if (s_q.enhanced_feature[uafc_pkg::EFR_ENH]) begin
            s_d.interrupt_enable[7:4] = REG_REQ_I.wdata[7:4];
          end
        end
        uafc_pkg::IDX_FCR_ISR: begin
          s_d.fifo_en = REG_REQ_I.wdata[0];
          if (REG_REQ_I.wdata[1] || REG_REQ_I.wdata[0] != s_q.fifo_en) begin
            s_d.rx_wp = 6'h00;
            s_d.rx_rp = 6'h00;
            s_d.rx_n = 7'h00;
          end
          if (REG_REQ_I.wdata[2] || REG_REQ_I.wdata[0] != s_q.fifo_en) begin
            s_d.tx_wp = 6'h00;
            s_d.tx_rp = 6'h00;
            s_d.tx_n = 7'h00;
          end
        end
        uafc_pkg::IDX_LCR: s_d.line_control = REG_REQ_I.wdata;
        uafc_pkg::IDX_MCR: s_d.modem_control = REG_REQ_I.wdata;
        uafc_pkg::IDX_TCR: s_d.flow_threshold = REG_REQ_I.wdata;
        uafc_pkg::IDX_TRIG: s_d.trig = REG_REQ_I.wdata;
        uafc_pkg::IDX_EFR: s_d.enhanced_feature = REG_REQ_I.wdata;
        uafc_pkg::IDX_DLD: s_d.fractional_divisor = REG_REQ_I.wdata;
        default: ;
      endcase
    end
    // host reads, answered one clock later from a flop
    if (REG_REQ_I.rd) begin
      case (REG_REQ_I.addr)
        uafc_pkg::IDX_DATA: begin
          s_d.rdata = s_q.rxf[s_q.rx_rp][7:0];
          if (s_q.rx_n != 7'h00) begin
            s_d.rx_rp = s_q.rx_rp + 6'h01;
            rx_pop = 1'b1;
          end
        end
        uafc_pkg::IDX_IER: s_d.rdata = s_q.interrupt_enable;
        uafc_pkg::IDX_FCR_ISR: begin
          s_d.rdata = isr_v;
          if (isr_v == uafc_pkg::ISR_THR) begin
            s_d.thr_arm = 1'b0;
          end
          if (isr_v == uafc_pkg::ISR_FLOW) begin
            s_d.flow_flag = 1'b0;
          end
        end
        uafc_pkg::IDX_LCR: s_d.rdata = s_q.line_control;
        uafc_pkg::IDX_MCR: s_d.rdata = s_q.modem_control;
        uafc_pkg::IDX_LSR: begin
          s_d.rdata = lsr_v;
          s_d.overrun = 1'b0;
        end
        uafc_pkg::IDX_TCR: s_d.rdata = s_q.flow_threshold;
        uafc_pkg::IDX_TRIG: s_d.rdata = s_q.trig;
        uafc_pkg::IDX_EFR: s_d.rdata = s_q.enhanced_feature;
        uafc_pkg::IDX_DLD: s_d.rdata = s_q.fractional_divisor;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // transmitter, advances only on sampling ticks
    if (tick) begin
      case (s_q.tx_st)
        uafc_pkg::TX_IDLE: begin
          // cts is looked at only between characters, so a frame always ends whole
          if (s_q.tx_n != 7'h00 && !cts_hold) begin
            s_d.tx_sh = s_q.txf[s_q.tx_rp] & wmask;
            s_d.tx_par = s_q.line_control[4] ? ^(s_q.txf[s_q.tx_rp] & wmask)
                                    : ~^(s_q.txf[s_q.tx_rp] & wmask);
            s_d.tx_rp = s_q.tx_rp + 6'h01;
            tx_pop = 1'b1;
            s_d.tx_tc = 5'h00;
            s_d.txd = 1'b0;
            s_d.tx_st = uafc_pkg::TX_START;
          end
        end
        default: begin
          s_d.tx_tc = s_q.tx_tc + 5'h01;
          if (s_q.tx_tc == len - 5'h01) begin
            s_d.tx_tc = 5'h00;
            case (s_q.tx_st)
              uafc_pkg::TX_START: begin
                s_d.txd = s_q.tx_sh[0];
                s_d.tx_bi = 3'h0;
                s_d.tx_st = uafc_pkg::TX_DATA;
              end
              uafc_pkg::TX_DATA: begin
                s_d.tx_sh = s_q.tx_sh >> 1;
                s_d.tx_bi = s_q.tx_bi + 3'h1;
                s_d.txd = s_q.tx_sh[1];
                if ({1'b0, s_q.tx_bi} == wl - 4'h1) begin
                  s_d.tx_bi = 3'h0;
                  s_d.txd = s_q.line_control[3] ? s_q.tx_par : 1'b1;
                  s_d.tx_st = s_q.line_control[3] ? uafc_pkg::TX_PAR : uafc_pkg::TX_STOP;
                end
              end
              uafc_pkg::TX_PAR: begin
                s_d.txd = 1'b1;
                s_d.tx_st = uafc_pkg::TX_STOP;
              end
              default: begin
                s_d.tx_bi = s_q.tx_bi + 3'h1;
                if (s_q.tx_bi == {2'h0, s_q.line_control[2]}) begin
                  s_d.tx_st = uafc_pkg::TX_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
    // receiver; each bit is taken at its centre
    if (tick) begin
      s_d.rx_prev = RXD_I;
      s_d.rx_tc = s_q.rx_tc + 5'h01;
      case (s_q.rx_st)
        uafc_pkg::RX_IDLE: begin
          s_d.rx_tc = 5'h00;
          if (s_q.rx_prev && !RXD_I) begin
            s_d.rx_sh = 8'h00;
            s_d.rx_pbit = 1'b0;
            s_d.rx_st = uafc_pkg::RX_START;
          end
        end
        uafc_pkg::RX_START: begin
          if (s_q.rx_tc + 5'h01 == half) begin
            s_d.rx_tc = 5'h00;
            s_d.rx_bi = 3'h0;
            // a glitch shorter than half a bit is thrown away
            s_d.rx_st = RXD_I ? uafc_pkg::RX_IDLE : uafc_pkg::RX_DATA;
          end
        end
        default: begin
          if (s_q.rx_tc == len - 5'h01) begin
            s_d.rx_tc = 5'h00;
            case (s_q.rx_st)
              uafc_pkg::RX_DATA: begin
                s_d.rx_sh[s_q.rx_bi] = RXD_I;
                s_d.rx_bi = s_q.rx_bi + 3'h1;
                if ({1'b0, s_q.rx_bi} == wl - 4'h1) begin
                  s_d.rx_st = s_q.line_control[3] ? uafc_pkg::RX_PAR : uafc_pkg::RX_STOP;
                end
              end
              uafc_pkg::RX_PAR: begin
                s_d.rx_pbit = RXD_I;
                s_d.rx_st = uafc_pkg::RX_STOP;
              end
              default: begin
                // tags: break, framing, parity above the byte
                rx_word[7:0] = s_q.rx_sh;
                rx_word[8] = s_q.line_control[3] &&
                  ((^s_q.rx_sh ^ s_q.rx_pbit) != ~s_q.line_control[4]);
                rx_word[9] = !RXD_I;
                rx_word[10] = (s_q.rx_sh == 8'h00) && !RXD_I && !s_q.rx_pbit;
                s_d.rx_st = uafc_pkg::RX_IDLE;
                // storing goes on whatever the rts line shows
                if (s_q.rx_n < cap) begin
                  s_d.rxf[s_q.rx_wp] = rx_word;
                  s_d.rx_wp = s_q.rx_wp + 6'h01;
                  rx_push = 1'b1;
                end else begin
                  s_d.overrun = 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end
    // fill counters, one update each so push and pop may coincide
    s_d.tx_n = s_d.tx_n + {6'h00, tx_push} - {6'h00, tx_pop};
    s_d.rx_n = s_d.rx_n + {6'h00, rx_push} - {6'h00, rx_pop};
    // timeout restarts on any rx fifo movement
    if (s_q.rx_n == 7'h00 || rx_push || rx_pop) begin
      s_d.to_cnt = 10'h000;
      s_d.to_flag = 1'b0;
    end else if (tick && !s_q.to_flag) begin
      s_d.to_cnt = s_q.to_cnt + 10'h001;
      if (s_q.to_cnt == to_lim - 10'h001) begin
        s_d.to_flag = 1'b1;
      end
    end
    // tx empty event on the rising edge of its condition
    s_d.thr_cond = s_q.fifo_en ? (s_q.tx_n < tx_trig) : (s_q.tx_n == 7'h00);
    if (s_d.thr_cond && !s_q.thr_cond) begin
      s_d.thr_arm = 1'b1;
    end
    // rts: manual, or hysteresis between halt and resume levels
    if (!s_q.modem_control[1]) begin
      s_d.rts_n = 1'b1;
    end else if (!s_q.enhanced_feature[uafc_pkg::EFR_ARTS]) begin
      s_d.rts_n = 1'b0;
    end else if (s_q.rx_n >= halt_lvl) begin
      s_d.rts_n = 1'b1;
    end else if (s_q.rx_n <= resume_lvl) begin
      s_d.rts_n = 1'b0;
    end
    s_d.cts_prev = CTS_N_I;
    if (s_q.enhanced_feature[uafc_pkg::EFR_ENH] && s_q.interrupt_enable[6] && s_d.rts_n && !s_q.rts_n) begin
      s_d.flow_flag = 1'b1;
    end
    if (s_q.enhanced_feature[uafc_pkg::EFR_ENH] && s_q.interrupt_enable[7] && CTS_N_I && !s_q.cts_prev) begin
      s_d.flow_flag = 1'b1;
    end
  end

  // one register for the whole state
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
      s_q.line_control <= uafc_pkg::RST_LCR;
      s_q.txd <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.rts_n <= 1'b1;
      s_q.cts_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_O = s_q.rdata;
  assign TXD_O = s_q.txd;
  assign RTS_N_O = s_q.rts_n;
  assign IRQ_O = s_q.irq;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  sequence seq_tx_launch;
    SAMPLE_TICK_I && s_q.tx_st == uafc_pkg::TX_IDLE && s_q.tx_n != 7'h00 && !cts_hold;
  endsequence
  sequence seq_start_centre;
    SAMPLE_TICK_I && s_q.rx_st == uafc_pkg::RX_START && s_q.rx_tc + 5'h01 == half;
  endsequence

  AST_TX_START_LOW: assert property (seq_tx_launch |=> !TXD_O && s_q.tx_st == uafc_pkg::TX_START)
    else $error("start bit not driven low");
  AST_TX_PUSH: assert property (REG_REQ_I.wr && REG_REQ_I.addr == uafc_pkg::IDX_DATA
    && s_q.fifo_en && s_q.tx_n < uafc_pkg::FIFO_FULL |=> s_q.tx_wp == $past(s_q.tx_wp) + 6'h01)
    else $error("tx write pointer did not advance");
  // status checked through the read path, not through its own expression
  AST_THRE_EMPTY: assert property (REG_REQ_I.rd && REG_REQ_I.addr == uafc_pkg::IDX_LSR
    && s_q.tx_n == 7'h00 |=> REG_RDATA_O[5])
    else $error("holding empty flag missing");
  AST_TEMT: assert property (REG_REQ_I.rd && REG_REQ_I.addr == uafc_pkg::IDX_LSR
    && (s_q.tx_n != 7'h00 || s_q.tx_st != uafc_pkg::TX_IDLE) |=> !REG_RDATA_O[6])
    else $error("tx empty with data pending");
  AST_CTS_HOLD: assert property (cts_hold && s_q.tx_st == uafc_pkg::TX_IDLE
    |=> s_q.tx_st == uafc_pkg::TX_IDLE)
    else $error("tx started while cts high");
  AST_START_REJECT: assert property (seq_start_centre ##0 RXD_I
    |=> s_q.rx_st == uafc_pkg::RX_IDLE && s_q.rx_wp == $past(s_q.rx_wp))
    else $error("false start not discarded");
  AST_START_ACCEPT: assert property (seq_start_centre ##0 !RXD_I
    |=> s_q.rx_st == uafc_pkg::RX_DATA && s_q.rx_tc == 5'h00)
    else $error("valid start bit rejected");
  AST_RHR_POP: assert property (REG_REQ_I.rd && REG_REQ_I.addr == uafc_pkg::IDX_DATA
    && s_q.rx_n != 7'h00 |=> s_q.rx_rp == $past(s_q.rx_rp) + 6'h01)
    else $error("rx read did not advance");
  AST_RTS_HALT: assert property (auto_rts && s_q.rx_n >= halt_lvl |=> RTS_N_O)
    else $error("rts not raised at halt level");
  AST_RTS_RESUME: assert property (auto_rts && s_q.rx_n <= resume_lvl
    && s_q.rx_n < halt_lvl |=> !RTS_N_O)
    else $error("rts not lowered at resume level");
  // enables taken from the cycle in which the edge was decided
  AST_RTS_INT: assert property ($past(s_q.enhanced_feature[uafc_pkg::EFR_ENH]) && $past(s_q.interrupt_enable[6])
    && $rose(RTS_N_O) |-> s_q.flow_flag)
    else $error("rts edge did not set status");
  AST_CTS_INT: assert property (s_q.enhanced_feature[uafc_pkg::EFR_ENH] && s_q.interrupt_enable[7]
    && CTS_N_I && !s_q.cts_prev |=> s_q.flow_flag)
    else $error("cts edge did not set status");
endmodule // uafc_core

// ---- verification/uafc_remote.sv ----
`timescale 1ns/1ps
// ****************************************
// remote uart on the serial side
// ****************************************
module uafc_remote (
  input wire logic clk_i,
  input wire logic tick_i,
  input wire logic [4:0] len_i,
  input wire logic cts_n_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  logic [8:0] tq[$]; // bit 8 asks for a short false start instead of a byte
  logic busy = 1'b0;
  // waits for n sampling ticks, shared by both directions so it must be automatic
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (!tick_i) @(posedge clk_i);
    end
  endtask
  // sender: clear-to-send is looked at only between characters
  initial begin
    logic [9:0] sh;
    logic [8:0] e;
    txd_o = 1'b1;
    forever begin
      @(posedge clk_i);
      if (tick_i && !cts_n_i && tq.size() != 0) begin
        busy = 1'b1;
        e = tq.pop_front();
        sh = {1'b1, e[7:0], 1'b0};
        if (e[8]) begin
          txd_o <= 1'b0;
          ticks(1);
          txd_o <= 1'b1;
          ticks(len_i);
        end else begin
          for (int i = 0; i < 10; i++) begin
            txd_o <= sh[i];
            ticks(len_i);
          end
        end
        busy = 1'b0;
      end
    end
  end
  // receiver: centre sampling of eight data bits, then waits to the centre of the stop bit without sampling it
  initial begin
    logic [7:0] b;
    got_o = 1'b0;
    got_byte_o = 8'h00;
    forever begin
      @(posedge clk_i);
      got_o <= 1'b0;
      if (tick_i && !rxd_i) begin
        ticks(len_i / 2);
        for (int i = 0; i < 8; i++) begin
          ticks(len_i);
          b[i] = rxd_i;
        end
        ticks(len_i);
        got_byte_o <= b;
        got_o <= 1'b1;
      end
    end
  end
endmodule // uafc_remote

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ****************************************
// bench for the uart core
// ****************************************
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  uafc_pkg::uafc_req_t req = '0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic cts_n = 1'b0;
  logic rts_n;
  logic irq;
  logic got;
  logic [7:0] got_b;
  logic [4:0] len = 5'h10;
  logic [15:0] exp_rd[$]; // {mask, masked value}
  logic [7:0] exp_ser[$];
  logic [15:0] e;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h0000b7e4;
  int n_errors = 0;
  int total_checks = 0;

  uafc_core dut (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .SAMPLE_TICK_I(tick), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd), .CTS_N_I(cts_n),
    .RTS_N_O(rts_n), .IRQ_O(irq)
  );
  uafc_remote rem (
    .clk_i(clk), .tick_i(tick), .len_i(len), .cts_n_i(rts_n), .rxd_i(txd),
    .txd_o(rxd), .got_o(got), .got_byte_o(got_b)
  );

  always #4 clk = ~clk;
  // sampling tick every other cycle keeps frames short
  always @(posedge clk) tick <= ~tick;

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    exp_rd.push_back({m, x & m});
    @(posedge clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
  endtask

  // waits until the remote has sent everything, then lets the push land
  task automatic idle();
    for (int i = 0; i < 9000 && (rem.tq.size() != 0 || rem.busy); i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task automatic close_out();
    if (exp_ser.size() != 0 || exp_rd.size() != 0) n_errors++;
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // monitor: oldest note against each result
  // ****************************************
  always @(posedge clk) begin
    if (rd_seen && exp_rd.size() != 0) begin
      e = exp_rd.pop_front();
      if (e[15:8] != 8'h00) check(rdata & e[15:8], e[7:0]);
    end
    if (got) check(got_b, exp_ser.size() != 0 ? exp_ser.pop_front() : ~got_b);
    rd_seen <= req.rd;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [7:0] b;
    logic [7:0] sent[$];
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(uafc_pkg::IDX_LSR, 8'hff, 8'h60);
    rd(uafc_pkg::IDX_LCR, 8'hff, uafc_pkg::RST_LCR);
    rd(4'hf, 8'hff, 8'h00);
    wr(uafc_pkg::IDX_FCR_ISR, 8'h01);
    // rts is high out of reset; the remote only sends while it is low
    wr(uafc_pkg::IDX_MCR, 8'h02);
    // every oversampling rate, both directions at once
    for (int m = 0; m < 3; m++) begin
      wr(uafc_pkg::IDX_DLD, {2'h0, m[1:0], 4'h0});
      len = 5'h10 >> m;
      for (int k = 0; k < 4; k++) begin
        b = rnd();
        exp_ser.push_back(b);
        wr(uafc_pkg::IDX_DATA, b);
      end
      rd(uafc_pkg::IDX_LSR, 8'h60, 8'h00);
      b = rnd();
      rem.tq.push_back(9'h100);
      rem.tq.push_back({1'b0, b});
      idle();
      rd(uafc_pkg::IDX_LSR, 8'h1f, 8'h01);
      rd(uafc_pkg::IDX_DATA, 8'hff, b);
      rd(uafc_pkg::IDX_LSR, 8'h01, 8'h00);
      for (int i = 0; i < 9000 && exp_ser.size() != 0; i++) @(posedge clk);
      repeat (8 * len) @(posedge clk);
      rd(uafc_pkg::IDX_LSR, 8'h60, 8'h60);
    end
    // single holding place: empties while the shifter still works
    wr(uafc_pkg::IDX_FCR_ISR, 8'h00);
    wr(uafc_pkg::IDX_IER, 8'h02);
    b = rnd();
    exp_ser.push_back(b);
    wr(uafc_pkg::IDX_DATA, b);
    repeat (16) @(posedge clk);
    rd(uafc_pkg::IDX_LSR, 8'h60, 8'h20);
    rd(uafc_pkg::IDX_FCR_ISR, 8'hff, uafc_pkg::ISR_THR);
    for (int i = 0; i < 9000 && exp_ser.size() != 0; i++) @(posedge clk);
    // automatic request-to-send with halt 8 and resume 4
    wr(uafc_pkg::IDX_FCR_ISR, 8'h01);
    wr(uafc_pkg::IDX_MCR, 8'h00);
    wr(uafc_pkg::IDX_TRIG, 8'hf0);
    wr(uafc_pkg::IDX_TCR, 8'h12);
    wr(uafc_pkg::IDX_EFR, 8'h50);
    wr(uafc_pkg::IDX_IER, 8'h40);
    check({7'h00, rts_n}, 8'h01);
    wr(uafc_pkg::IDX_MCR, 8'h02);
    repeat (2) @(posedge clk);
    check({7'h00, rts_n}, 8'h00);
    for (int k = 0; k < 12; k++) begin
      b = rnd();
      sent.push_back(b);
      rem.tq.push_back({1'b0, b});
    end
    for (int i = 0; i < 9000 && rts_n !== 1'b1; i++) @(posedge clk);
    check({7'h00, rts_n}, 8'h01);
    repeat (100) @(posedge clk);
    check({7'h00, irq}, 8'h01);
    rd(uafc_pkg::IDX_FCR_ISR, 8'hff, 8'h20);
    repeat (5) rd(uafc_pkg::IDX_DATA, 8'hff, sent.pop_front());
    repeat (4) @(posedge clk);
    check({7'h00, rts_n}, 8'h00);
    idle();
    while (sent.size() != 0) rd(uafc_pkg::IDX_DATA, 8'hff, sent.pop_front());
    // receive timeout after (4*8+12) bit times, then trigger at any data
    wr(uafc_pkg::IDX_IER, 8'h01);
    b = rnd();
    rem.tq.push_back({1'b0, b});
    idle();
    check({7'h00, irq}, 8'h00);
    repeat (360) @(posedge clk);
    check({7'h00, irq}, 8'h01);
    rd(uafc_pkg::IDX_FCR_ISR, 8'hff, uafc_pkg::ISR_TOUT);
    rd(uafc_pkg::IDX_DATA, 8'hff, b);
    wr(uafc_pkg::IDX_TRIG, 8'h00);
    b = rnd();
    rem.tq.push_back({1'b0, b});
    idle();
    rd(uafc_pkg::IDX_FCR_ISR, 8'hff, uafc_pkg::ISR_RXD);
    rd(uafc_pkg::IDX_DATA, 8'hff, b);
    // automatic clear-to-send holds the start of the next frame
    wr(uafc_pkg::IDX_EFR, 8'hd0);
    wr(uafc_pkg::IDX_IER, 8'h80);
    cts_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(uafc_pkg::IDX_FCR_ISR, 8'hff, uafc_pkg::ISR_FLOW);
    b = rnd();
    exp_ser.push_back(b);
    wr(uafc_pkg::IDX_DATA, b);
    repeat (200) @(posedge clk);
    check({7'h00, txd}, 8'h01);
    cts_n <= 1'b0;
    for (int i = 0; i < 9000 && exp_ser.size() != 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // tb
